//--- logic/oas_consts.svh
/*
 * Named constants of the operand addressing and status flag unit:
 * register byte addresses, command codes, instruction field slices,
 * status bit positions and fixed values.
 * Assumes it is included by bare name; holds definitions only.
 */
`ifndef OAS_CONSTS_SVH
`define OAS_CONSTS_SVH

// Register byte addresses
`define OAS_A_CMD    8'h00
`define OAS_A_INSTR  8'h04
`define OAS_A_EXT1   8'h08
`define OAS_A_EXT2   8'h0C
`define OAS_A_SRCV   8'h10
`define OAS_A_DSTV   8'h14
`define OAS_A_PC     8'h18
`define OAS_A_STATUS 8'h1C
`define OAS_A_SRC_EA 8'h20
`define OAS_A_DST_EA 8'h24
`define OAS_A_OPND   8'h28
`define OAS_A_RESULT 8'h2C
`define OAS_A_CRU    8'h30
`define OAS_A_XWORDS 8'h34
`define OAS_A_SHCNT  8'h38
`define OAS_WR_PAGE  2'h2
`define OAS_F_PAGE   7:6
`define OAS_F_WIDX   5:2
`define OAS_NUM_WR   16

// Command codes
`define OAS_OP_NOP  5'h00
`define OAS_OP_ADDR 5'h01
`define OAS_OP_IMM  5'h02
`define OAS_OP_WRB  5'h03
`define OAS_OP_JUMP 5'h04
`define OAS_OP_CRU  5'h05
`define OAS_OP_CMP  5'h06
`define OAS_OP_ADD  5'h07
`define OAS_OP_ADDI 5'h08
`define OAS_OP_SUB  5'h09
`define OAS_OP_INC  5'h0A
`define OAS_OP_ABS  5'h0B
`define OAS_OP_NEG  5'h0C
`define OAS_OP_SLA  5'h0D
`define OAS_OP_MOV  5'h0E
`define OAS_OP_TB   5'h0F
`define OAS_OP_XOP  5'h10
`define OAS_OP_LOAD_MASK_IMMEDIATE 5'h11
`define OAS_OP_CONTEXT_RETURN 5'h12

// Instruction and command fields
`define OAS_F_OP    4:0
`define OAS_F_BYTE  12
`define OAS_F_TD    11:10
`define OAS_F_D     9:6
`define OAS_F_TS    5:4
`define OAS_F_S     3:0
`define OAS_F_DISP  7:0
`define OAS_F_SIGN  7
`define OAS_F_CRUB  12:1
`define OAS_F_UPPER 15:8
`define OAS_F_LOWER 7:0
`define OAS_F_MASK  3:0
`define OAS_F_SHC   3:0

// Status bit positions
`define OAS_ST_LGT 15
`define OAS_ST_AGT 14
`define OAS_ST_EQ  13
`define OAS_ST_CY  12
`define OAS_ST_OV  11
`define OAS_ST_PAR 10
`define OAS_ST_EXT 9

// Fixed values
`define OAS_INC_BYTE 16'h0001
`define OAS_INC_WORD 16'h0002
`define OAS_MOST_NEG 16'h8000
`define OAS_SYM_REG  4'h0
`define OAS_CRU_REG  4'hC
`define OAS_SAVE_REG 4'hF
`define OAS_SH_FULL  5'h10
`define OAS_ZERO     16'h0000
`define OAS_ZERO_BYTE 8'h00

`endif

//--- logic/oas_pkg.sv
/*
 * Types of the operand addressing and status flag unit.
 * Assumes oas_consts.svh is on the include path.
 */
package oas_pkg;
`include "oas_consts.svh"

   // Operand addressing modes
   typedef enum logic [1:0] {
      MD_REG  = 2'h0,
      MD_IND  = 2'h1,
      MD_SYM  = 2'h2,
      MD_AUTO = 2'h3
   } oas_mode_t;

   // Register bus request, one cycle per strobe
   typedef struct packed {
      logic [7:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } oas_bus_req_t;

endpackage : oas_pkg

//--- logic/oas_core.sv
/*
 * Operand effective address generation and status flag unit of a
 * 16-bit workspace register processor, with its workspace file.
 * Assumes a single-cycle register port master on ref_clk and an
 * asynchronous serial input bit that is synchronised here.
 */
// Local design decisions: the register offsets and the plain strobed port.
// Function
// - Register mode operand is the register itself
// - Indirect mode uses register as address
// - Auto-increment writes incremented value back
// - Increment is one for byte, two word
// - Byte field set means byte operation
// - Byte register operand uses upper byte only
// - Symbolic mode address is following word
// - Indexed address is base plus register
// - Register zero in indexed encoding means symbolic
// - Two extra words: source base, then destination
// - Immediate operand is the following word
// - Jump adds doubled displacement to counter
// - Serial bit address is base plus displacement
// - Compare sets logical greater from signs, difference
// - Arithmetic greater: result positive and nonzero; absolute value tests its operand
// - Equal from compare, serial bit, or zero
// - Carry from adder or last shifted bit
// - Left shift overflow when sign ever changes
// - Subtract overflow from differing sign rule
// - Immediate add and increment overflow rules
// - Negate and absolute overflow only on 8000
// - Byte parity flag set on odd ones
// - Trap instruction sets extended operation flag
// - Mask loads from immediate or saved status
// - Mode field decodes four addressing modes
`timescale 1ns/10ps
`include "oas_consts.svh"

module oas_core (
   input  wire logic                  ref_clk,
   input  wire logic                  rst_b,
   input  wire oas_pkg::oas_bus_req_t bus_req,
   input  wire logic                  serial_io_input_bit,
   output logic [15:0]                rd_data,
   output logic [15:0]                status_word
);

   // Workspace register file and block registers
   logic [15:0] wr_file [`OAS_NUM_WR];  // Workspace registers
   logic [15:0] next_wr [`OAS_NUM_WR];  // Next workspace values
   logic [15:0] instr;                  // Instruction word
   logic [15:0] ext1;                   // First following word
   logic [15:0] ext2;                   // Second following word
   logic [15:0] srcv;                   // Source operand value
   logic [15:0] dstv;                   // Destination operand value
   logic [15:0] pc;                     // Program counter
   logic [15:0] src_ea;                 // Source effective address
   logic [15:0] dst_ea;                 // Destination effective address
   logic [15:0] operand;                // Fetched source operand
   logic [15:0] result;                 // Last flag op result
   logic [11:0] cru_addr;               // Selected serial bit address
   logic [1:0]  extra_words;            // Words after instruction
   logic [3:0]  shift_cnt;              // Shift count
   logic        sio_meta;               // Synchroniser first stage
   logic        sio_sync;               // Synchronised serial bit

   // Command decode
   wire        go     = bus_req.wr && (bus_req.addr == `OAS_A_CMD);
   wire [4:0]  op     = bus_req.wdata[`OAS_F_OP];
   wire        do_addr = go && (op == `OAS_OP_ADDR);
   wire        do_imm  = go && (op == `OAS_OP_IMM);
   wire        do_wrb  = go && (op == `OAS_OP_WRB);
   wire        do_jump = go && (op == `OAS_OP_JUMP);
   wire        do_cru  = go && (op == `OAS_OP_CRU);

   // Instruction fields
   wire        byte_op = instr[`OAS_F_BYTE];
   wire [3:0]  f_s     = instr[`OAS_F_S];
   wire [3:0]  f_d     = instr[`OAS_F_D];
   wire oas_pkg::oas_mode_t source_mode_field =
      oas_pkg::oas_mode_t'(instr[`OAS_F_TS]);
   wire oas_pkg::oas_mode_t dest_mode_field =
      oas_pkg::oas_mode_t'(instr[`OAS_F_TD]);
   wire [15:0] sel_s_val = wr_file[f_s];                  // Source register
   wire [15:0] sel_d_val = wr_file[f_d];                  // Destination register

   // Increment amount by operand size
   wire [15:0] inc_amt = byte_op ? `OAS_INC_BYTE : `OAS_INC_WORD;

   // Mode 10 takes a following word; register zero makes it symbolic
   wire src_xw  = (source_mode_field == oas_pkg::MD_SYM);
   wire dst_xw  = (dest_mode_field == oas_pkg::MD_SYM);
   wire src_sym = src_xw && (f_s == `OAS_SYM_REG);
   wire dst_sym = dst_xw && (f_d == `OAS_SYM_REG);

   // Source base comes first, destination base second
   wire [15:0] src_base = ext1;
   wire [15:0] dst_base = src_xw ? ext2 : ext1;

   // Effective address of one operand from its mode
   function automatic logic [15:0] oas_ea(
      input oas_pkg::oas_mode_t m,
      input logic [15:0]        rv,
      input logic [15:0]        base,
      input logic               sym
   );
      logic [15:0] ea;
      ea = `OAS_ZERO;
      case (m)
         oas_pkg::MD_REG:  ea = `OAS_ZERO;                // No memory access
         oas_pkg::MD_IND:  ea = rv;
         oas_pkg::MD_AUTO: ea = rv;
         oas_pkg::MD_SYM:  ea = sym ? base : base + rv;
         default:          ea = `OAS_ZERO;
      endcase
      return ea;
   endfunction : oas_ea

   wire [15:0] next_src_ea = oas_ea(source_mode_field, sel_s_val, src_base, src_sym);
   wire [15:0] next_dst_ea = oas_ea(dest_mode_field, sel_d_val, dst_base, dst_sym);

   // Register mode operand, upper byte only for byte ops
   wire [15:0] reg_opnd = byte_op ?
      {sel_s_val[`OAS_F_UPPER], `OAS_ZERO_BYTE} : sel_s_val;
   wire [15:0] next_operand =
      (source_mode_field == oas_pkg::MD_REG) ? reg_opnd : `OAS_ZERO;

   // Auto-increment requests for each operand
   wire inc_s = do_addr && (source_mode_field == oas_pkg::MD_AUTO);
   wire inc_d = do_addr && (dest_mode_field == oas_pkg::MD_AUTO);

   // Byte writes keep the lower byte of the register
   wire [15:0] wrb_val = byte_op ?
      {srcv[`OAS_F_UPPER], sel_d_val[`OAS_F_LOWER]} : srcv;

   // Workspace register file, one entry per generate step
   for (genvar gi = 0; gi < `OAS_NUM_WR; gi++) begin : g_wr
      wire hit_bus = bus_req.wr &&
                     (bus_req.addr[`OAS_F_PAGE] == `OAS_WR_PAGE) &&
                     (bus_req.addr[`OAS_F_WIDX] == 4'(gi));
      wire [15:0] add_s = (inc_s && f_s == 4'(gi)) ? inc_amt : `OAS_ZERO;
      wire [15:0] add_d = (inc_d && f_d == 4'(gi)) ? inc_amt : `OAS_ZERO;
      // Bus write, byte-merged store, else write-back increment
      assign next_wr[gi] = hit_bus ? bus_req.wdata :
                           (do_wrb && f_d == 4'(gi)) ? wrb_val :
                           wr_file[gi] + add_s + add_d;
      // Register storage
      always_ff @(posedge ref_clk) begin
         if (!rst_b) begin
            wr_file[gi] <= `OAS_ZERO;
         end else begin
            wr_file[gi] <= next_wr[gi];
         end
      end
   end

   // Program counter relative target, displacement doubled
   wire [15:0] disp_word = {{7{instr[`OAS_F_SIGN]}}, instr[`OAS_F_DISP], 1'b0};
   wire [15:0] next_pc = pc + disp_word;

   // Serial bit address from base register and displacement
   wire [11:0] disp_bit = {{4{instr[`OAS_F_SIGN]}}, instr[`OAS_F_DISP]};
   wire [11:0] next_cru =
      wr_file[`OAS_CRU_REG][`OAS_F_CRUB] + disp_bit;

   // Flag unit operands and op groups
   wire [15:0] a_s = (op == `OAS_OP_ADDI) ? ext1 : srcv;
   wire [15:0] a_d = dstv;
   wire [4:0]  sh_amt = (shift_cnt == 4'h0) ? `OAS_SH_FULL : {1'b0, shift_cnt};
   wire is_res = (op == `OAS_OP_ADD) || (op == `OAS_OP_ADDI) ||
                 (op == `OAS_OP_SUB) || (op == `OAS_OP_INC) ||
                 (op == `OAS_OP_NEG) || (op == `OAS_OP_SLA) ||
                 (op == `OAS_OP_MOV) || (op == `OAS_OP_ABS);
   wire do_flag = go && (is_res || (op == `OAS_OP_CMP) ||
                  (op == `OAS_OP_TB) || (op == `OAS_OP_XOP) ||
                  (op == `OAS_OP_LOAD_MASK_IMMEDIATE) || (op == `OAS_OP_CONTEXT_RETURN));

   logic [16:0] sum;          // Adder with carry out
   logic [15:0] res;          // Result of the flag op
   logic [31:0] shx;          // Sign-extended shift window
   logic [15:0] next_status;  // Status after the flag op

   // Result and flag computation
   always_comb begin
      next_status = status_word;
      sum = 17'h00000;
      res = `OAS_ZERO;
      shx = 32'h00000000;
      case (op)
         `OAS_OP_CMP: begin
            sum = {1'b0, a_d} + {1'b0, ~a_s} + 17'h00001;
            next_status[`OAS_ST_LGT] = (a_s[15] & ~a_d[15]) |
               ((a_s[15] == a_d[15]) & sum[15]);
            next_status[`OAS_ST_AGT] = (~a_s[15] & a_d[15]) |
               ((a_s[15] == a_d[15]) & sum[15]);
            next_status[`OAS_ST_EQ]  = (a_s == a_d);
            if (byte_op) begin
               next_status[`OAS_ST_PAR] = ^a_s[`OAS_F_UPPER];
            end
         end
         `OAS_OP_ADD, `OAS_OP_ADDI: begin
            sum = {1'b0, a_d} + {1'b0, a_s};
            res = sum[15:0];
            next_status[`OAS_ST_CY] = sum[16];
            next_status[`OAS_ST_OV] = (a_s[15] == a_d[15]) &&
                                      (res[15] != a_d[15]);
         end
         `OAS_OP_SUB: begin
            sum = {1'b0, a_d} + {1'b0, ~a_s} + 17'h00001;
            res = sum[15:0];
            next_status[`OAS_ST_CY] = sum[16];
            next_status[`OAS_ST_OV] = (a_s[15] != a_d[15]) &&
                                      (res[15] != a_d[15]);
         end
         `OAS_OP_INC: begin
            sum = {1'b0, a_s} + 17'h00001;
            res = sum[15:0];
            next_status[`OAS_ST_CY] = sum[16];
            next_status[`OAS_ST_OV] = ~a_s[15] & res[15];
         end
         `OAS_OP_ABS: begin
            sum = a_s[15] ? ({1'b0, ~a_s} + 17'h00001) : {1'b0, a_s};
            res = sum[15:0];
            next_status[`OAS_ST_CY] = a_s[15] & sum[16];
            next_status[`OAS_ST_OV] = (a_s == `OAS_MOST_NEG);
         end
         `OAS_OP_NEG: begin
            sum = {1'b0, ~a_s} + 17'h00001;
            res = sum[15:0];
            next_status[`OAS_ST_CY] = sum[16];
            next_status[`OAS_ST_OV] = (a_s == `OAS_MOST_NEG);
         end
         `OAS_OP_SLA: begin
            shx = {{16{a_s[15]}}, a_s} << sh_amt;
            res = shx[15:0];
            next_status[`OAS_ST_CY] = shx[16];
            next_status[`OAS_ST_OV] = (shx[31:15] != {17{a_s[15]}});
         end
         `OAS_OP_MOV: begin
            res = a_s;
         end
         `OAS_OP_TB: begin
            next_status[`OAS_ST_EQ] = sio_sync;
         end
         `OAS_OP_XOP: begin
            next_status[`OAS_ST_EXT] = 1'b1;
         end
         `OAS_OP_LOAD_MASK_IMMEDIATE: begin
            next_status[`OAS_F_MASK] = ext1[`OAS_F_MASK];
         end
         `OAS_OP_CONTEXT_RETURN: begin
            next_status = wr_file[`OAS_SAVE_REG];
         end
         default: begin
            next_status = status_word;
         end
      endcase
      // Result compared to zero; absolute value compares its operand
      if (is_res) begin
         if (op == `OAS_OP_ABS) begin
            next_status[`OAS_ST_LGT] = (a_s != `OAS_ZERO);
            next_status[`OAS_ST_AGT] = ~a_s[15] && (a_s != `OAS_ZERO);
            next_status[`OAS_ST_EQ]  = (a_s == `OAS_ZERO);
         end else begin
            next_status[`OAS_ST_LGT] = (res != `OAS_ZERO);
            next_status[`OAS_ST_AGT] = ~res[15] && (res != `OAS_ZERO);
            next_status[`OAS_ST_EQ]  = (res == `OAS_ZERO);
         end
         if (byte_op) begin
            next_status[`OAS_ST_PAR] = ^res[`OAS_F_UPPER];
         end
      end
   end

   // Read selection
   wire [15:0] rd_mux =
      (bus_req.addr[`OAS_F_PAGE] == `OAS_WR_PAGE) ? wr_file[bus_req.addr[`OAS_F_WIDX]] :
      (bus_req.addr == `OAS_A_CMD)    ? status_word :
      (bus_req.addr == `OAS_A_INSTR)  ? instr :
      (bus_req.addr == `OAS_A_EXT1)   ? ext1 :
      (bus_req.addr == `OAS_A_EXT2)   ? ext2 :
      (bus_req.addr == `OAS_A_SRCV)   ? srcv :
      (bus_req.addr == `OAS_A_DSTV)   ? dstv :
      (bus_req.addr == `OAS_A_PC)     ? pc :
      (bus_req.addr == `OAS_A_STATUS) ? status_word :
      (bus_req.addr == `OAS_A_SRC_EA) ? src_ea :
      (bus_req.addr == `OAS_A_DST_EA) ? dst_ea :
      (bus_req.addr == `OAS_A_OPND)   ? operand :
      (bus_req.addr == `OAS_A_RESULT) ? result :
      (bus_req.addr == `OAS_A_CRU)    ? {4'h0, cru_addr} :
      (bus_req.addr == `OAS_A_XWORDS) ? {14'h0000, extra_words} :
      (bus_req.addr == `OAS_A_SHCNT)  ? {12'h000, shift_cnt} : `OAS_ZERO;

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         rd_data <= `OAS_ZERO;
      end else begin
         rd_data <= bus_req.rd ? rd_mux : `OAS_ZERO;
      end
   end

   // Serial input synchroniser
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         sio_meta <= 1'b0;
         sio_sync <= 1'b0;
      end else begin
         sio_meta <= serial_io_input_bit;
         sio_sync <= sio_meta;
      end
   end

   // Software-written operand registers
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         instr     <= `OAS_ZERO;
         ext1      <= `OAS_ZERO;
         ext2      <= `OAS_ZERO;
         srcv      <= `OAS_ZERO;
         dstv      <= `OAS_ZERO;
         shift_cnt <= 4'h0;
      end else if (bus_req.wr) begin
         if (bus_req.addr == `OAS_A_INSTR) instr <= bus_req.wdata;
         if (bus_req.addr == `OAS_A_EXT1)  ext1  <= bus_req.wdata;
         if (bus_req.addr == `OAS_A_EXT2)  ext2  <= bus_req.wdata;
         if (bus_req.addr == `OAS_A_SRCV)  srcv  <= bus_req.wdata;
         if (bus_req.addr == `OAS_A_DSTV)  dstv  <= bus_req.wdata;
         if (bus_req.addr == `OAS_A_SHCNT) shift_cnt <= bus_req.wdata[`OAS_F_SHC];
      end
   end

   // Program counter: bus load or relative jump
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         pc <= `OAS_ZERO;
      end else if (bus_req.wr && bus_req.addr == `OAS_A_PC) begin
         pc <= bus_req.wdata;
      end else if (do_jump) begin
         pc <= next_pc;
      end
   end

   // Address decode results
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         src_ea      <= `OAS_ZERO;
         dst_ea      <= `OAS_ZERO;
         operand     <= `OAS_ZERO;
         extra_words <= 2'h0;
      end else if (do_addr) begin
         src_ea      <= next_src_ea;
         dst_ea      <= next_dst_ea;
         operand     <= next_operand;
         extra_words <= {1'b0, src_xw} + {1'b0, dst_xw};
      end else if (do_imm) begin
         operand     <= ext1;
      end
   end

   // Serial bit address
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         cru_addr <= 12'h000;
      end else if (do_cru) begin
         cru_addr <= next_cru;
      end
   end

   // Status word and result
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         status_word <= `OAS_ZERO;
         result      <= `OAS_ZERO;
      end else if (do_flag) begin
         status_word <= next_status;
         result      <= res;
      end
   end

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   property p_reg_opnd;
      do_addr && source_mode_field == oas_pkg::MD_REG && !byte_op
         |=> operand == $past(sel_s_val);
   endproperty
   a_reg_opnd: assert property (p_reg_opnd) else $error("register operand wrong");

   property p_indirect;
      do_addr && source_mode_field == oas_pkg::MD_IND |=> src_ea == $past(sel_s_val);
   endproperty
   a_indirect: assert property (p_indirect) else $error("indirect address wrong");

   property p_autoinc;
      do_addr && source_mode_field == oas_pkg::MD_AUTO &&
      dest_mode_field != oas_pkg::MD_AUTO
         |=> sel_s_val == $past(sel_s_val) + (byte_op ? 16'h0001 : 16'h0002);
   endproperty
   a_autoinc: assert property (p_autoinc) else $error("auto increment wrong");

   property p_indexed;
      do_addr && src_xw && f_s != 4'h0 |=> src_ea == $past(ext1) + $past(sel_s_val);
   endproperty
   a_indexed: assert property (p_indexed) else $error("indexed address wrong");

   property p_two_words;
      do_addr && src_xw && dst_sym |=> dst_ea == $past(ext2) && extra_words == 2'h2;
   endproperty
   a_two_words: assert property (p_two_words) else $error("second base wrong");

   property p_jump;
      do_jump |=> pc == $past(pc) + $past(disp_word) ##1 $stable(pc) || $past(bus_req.wr);
   endproperty
   a_jump: assert property (p_jump) else $error("jump target wrong");

   property p_neg_ov;
      go && op == `OAS_OP_NEG |=> status_word[`OAS_ST_OV] == ($past(srcv) == 16'h8000);
   endproperty
   a_neg_ov: assert property (p_neg_ov) else $error("negate overflow wrong");

   property p_tb_eq;
      go && op == `OAS_OP_TB
         |=> status_word[`OAS_ST_EQ] == $past(sio_sync) && $stable(status_word[15:14]);
   endproperty
   a_tb_eq: assert property (p_tb_eq) else $error("test bit flag wrong");

   property p_xop;
      go && op == `OAS_OP_XOP |=> status_word[`OAS_ST_EXT];
   endproperty
   a_xop: assert property (p_xop) else $error("trap flag not set");

   c_autoinc: cover property (inc_s ##1 bus_req.rd);
   c_jump:    cover property (do_jump ##1 do_jump);
   c_sla_ov:  cover property (go && op == `OAS_OP_SLA ##1 status_word[`OAS_ST_OV]);

endmodule : oas_core

//--- bench/oas_core_tb.sv
/* Self-checking bench of the operand addressing and status flag unit.
   Assumes oas_consts.svh and oas_pkg are compiled ahead of it. */
`timescale 1ns/10ps
`include "oas_consts.svh"
module oas_core_tb;
   logic                  ref_clk = 1'b0;             // 200 MHz clock
   logic                  rst_b = 1'b0;               // Sync reset, low active
   oas_pkg::oas_bus_req_t bus_req = '0;               // Register port request
   logic                  serial_io_input_bit = 1'b0; // Serial input bit
   logic [15:0]           rd_data;                    // Read data
   logic [15:0]           status_word;                // Status flags
   int                    fails = 0;                  // Mismatch count
   int                    cmp_count = 0;              // Comparison count
   logic [15:0]           got;                        // Last read value

   // Device under test
   oas_core oas_core_i (.ref_clk(ref_clk), .rst_b(rst_b), .bus_req(bus_req),
      .serial_io_input_bit(serial_io_input_bit), .rd_data(rd_data),
      .status_word(status_word));

   // Clock, 5 ns period
   always #2.5 ref_clk = ~ref_clk;

   // Compare and log a mismatch
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   // One-cycle write strobe; effect settled on return
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      bus_req <= '{a, d, 1'b1, 1'b0};
      @(posedge ref_clk);
      bus_req.wr <= 1'b0;
      #1;
   endtask : wr

   // One-cycle read strobe; data taken in the following cycle only
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      bus_req <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge ref_clk);
      bus_req.rd <= 1'b0;
      #1 got = rd_data;
   endtask : rd

   // Issue a command code
   task automatic cmd(input logic [4:0] c);
      wr(`OAS_A_CMD, {11'h000, c});
   endtask : cmd

   // Addressing modes and extra words
   task automatic t_addr();
      wr(8'h84, 16'h1000);
      wr(`OAS_A_INSTR, 16'h1031);
      cmd(`OAS_OP_ADDR);
      rd(8'h84);
      chk(got, 16'h1001);
      wr(`OAS_A_INSTR, 16'h0031);
      cmd(`OAS_OP_ADDR);
      rd(8'h84);
      chk(got, 16'h1003);
      wr(`OAS_A_INSTR, 16'h0001);
      cmd(`OAS_OP_ADDR);
      rd(`OAS_A_OPND);
      chk(got, 16'h1003);
      wr(8'h88, 16'h0010);
      wr(8'h8C, 16'h0020);
      wr(`OAS_A_EXT1, 16'h0100);
      wr(`OAS_A_EXT2, 16'h0200);
      wr(`OAS_A_INSTR, 16'h08E2);
      cmd(`OAS_OP_ADDR);
      rd(`OAS_A_SRC_EA);
      chk(got, 16'h0110);
      rd(`OAS_A_DST_EA);
      chk(got, 16'h0220);
      rd(`OAS_A_XWORDS);
      chk(got, 16'h0002);
      // Both operands symbolic: source base first, destination base second
      wr(8'h80, 16'h0055);
      wr(`OAS_A_INSTR, 16'h0820);
      cmd(`OAS_OP_ADDR);
      rd(`OAS_A_SRC_EA);
      chk(got, 16'h0100);
      rd(`OAS_A_DST_EA);
      chk(got, 16'h0200);
      $display("t_addr finished");
   endtask : t_addr

   // Counter and serial relative addressing
   task automatic t_rel();
      wr(`OAS_A_PC, 16'h0100);
      wr(`OAS_A_INSTR, 16'h00FE);
      cmd(`OAS_OP_JUMP);
      rd(`OAS_A_PC);
      chk(got, 16'h00FC);
      wr(8'hB0, 16'h0040);
      wr(`OAS_A_INSTR, 16'h0005);
      cmd(`OAS_OP_CRU);
      rd(`OAS_A_CRU);
      chk(got, 16'h0025);
      $display("t_rel finished");
   endtask : t_rel

   // Status flags, checked through masks
   task automatic t_flags();
      serial_io_input_bit <= 1'b1;
      wr(`OAS_A_SRCV, 16'h8000);
      wr(`OAS_A_DSTV, 16'h0001);
      cmd(`OAS_OP_CMP);
      chk(status_word & 16'hA000, 16'h8000);
      wr(`OAS_A_SRCV, 16'h0001);
      wr(`OAS_A_DSTV, 16'h8000);
      cmd(`OAS_OP_SUB);
      chk(status_word & 16'h6800, 16'h4800);
      wr(`OAS_A_SRCV, 16'h8000);
      cmd(`OAS_OP_NEG);
      chk(status_word & 16'h0800, 16'h0800);
      wr(`OAS_A_SRCV, 16'h0001);
      wr(`OAS_A_DSTV, 16'h0001);
      cmd(`OAS_OP_NEG);
      chk(status_word & 16'h0800, 16'h0000);
      cmd(`OAS_OP_XOP);
      wr(`OAS_A_EXT1, 16'h000A);
      cmd(`OAS_OP_LOAD_MASK_IMMEDIATE);
      chk(status_word & 16'h020F, 16'h020A);
      cmd(`OAS_OP_TB);
      chk(status_word & 16'h2000, 16'h2000);
      serial_io_input_bit <= 1'b0;
      repeat (3) @(posedge ref_clk);
      cmd(`OAS_OP_TB);
      chk(status_word & 16'h2000, 16'h0000);
      $display("t_flags finished");
   endtask : t_flags

   // Immediate, byte store, arithmetic, shift and context return
   task automatic t_ops();
      wr(`OAS_A_EXT1, 16'h7FFF);
      cmd(`OAS_OP_IMM);
      rd(`OAS_A_OPND);
      chk(got, 16'h7FFF);
      wr(8'h84, 16'hAB12);
      wr(`OAS_A_INSTR, 16'h1001);
      cmd(`OAS_OP_ADDR);
      rd(`OAS_A_OPND);
      chk(got, 16'hAB00);
      wr(`OAS_A_INSTR, 16'h0011);
      cmd(`OAS_OP_ADDR);
      rd(`OAS_A_SRC_EA);
      chk(got, 16'hAB12);
      wr(8'h88, 16'h1234);
      wr(`OAS_A_SRCV, 16'h5AFF);
      wr(`OAS_A_INSTR, 16'h1080);
      cmd(`OAS_OP_WRB);
      rd(8'h88);
      chk(got, 16'h5A34);
      wr(`OAS_A_SRCV, 16'hFFFF);
      wr(`OAS_A_DSTV, 16'h0001);
      cmd(`OAS_OP_ADD);
      chk(status_word & 16'hF800, 16'h3000);
      wr(`OAS_A_SRCV, 16'h0700);
      cmd(`OAS_OP_MOV);
      chk(status_word & 16'hFC00, 16'hD400);
      wr(`OAS_A_SRCV, 16'h7FFF);
      cmd(`OAS_OP_INC);
      chk(status_word & 16'h1800, 16'h0800);
      wr(`OAS_A_SRCV, 16'hFFFE);
      cmd(`OAS_OP_ABS);
      chk(status_word & 16'hE800, 16'h8000);
      rd(`OAS_A_RESULT);
      chk(got, 16'h0002);
      cmd(`OAS_OP_ADDI);
      chk(status_word & 16'h1800, 16'h0800);
      wr(`OAS_A_SHCNT, 16'h0002);
      wr(`OAS_A_SRCV, 16'h0001);
      cmd(`OAS_OP_SLA);
      chk(status_word & 16'h1800, 16'h0000);
      wr(`OAS_A_SRCV, 16'h4001);
      cmd(`OAS_OP_SLA);
      chk(status_word & 16'h1800, 16'h1800);
      rd(`OAS_A_RESULT);
      chk(got, 16'h0004);
      wr(8'hBC, 16'h8005);
      cmd(`OAS_OP_CONTEXT_RETURN);
      rd(`OAS_A_STATUS);
      chk(got, 16'h8005);
      $display("t_ops finished");
   endtask : t_ops

   // Print counts and verdict, then stop
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : tally_and_finish

   // Main sequence, after a two-cycle reset
   initial begin
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      #1 chk(status_word, 16'h0000);
      t_addr();
      t_rel();
      t_flags();
      t_ops();
      tally_and_finish();
   end

   // Watchdog, far beyond the few hundred cycles needed
   initial begin
      #20000;
      fails++;
      tally_and_finish();
   end
endmodule : oas_core_tb
